// [bench/pic_mgmt_model.sv]
module pic_mgmt_model (
  input  wire logic        i_clk,
  input  wire logic [15:0] i_reg_rdata,
  input  wire logic        i_reg_rvalid,
  output logic      [4:0]  o_reg_addr,
  output logic             o_reg_rd,
  output logic             o_reg_wr,
  output logic      [15:0] o_reg_wdata
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    o_reg_addr  = 5'h00;
    o_reg_rd    = 1'b0;
    o_reg_wr    = 1'b0;
    o_reg_wdata = 16'h0000;
  end

  // released lines show the inverse so stale values cannot pass for live ones
  task automatic rd(input logic [4:0] a, output pic_pkg::pic_word_t d,
                    output bit ok);
    ok = 1'b0;
    d  = 16'h0000;
    @(negedge i_clk);
    o_reg_addr = a;
    o_reg_rd   = 1'b1;
    @(negedge i_clk);
    o_reg_rd   = 1'b0;
    o_reg_addr = ~a;
    for (int i = 0; i < 3 && !ok; i++) begin
      if (i_reg_rvalid === 1'b1) begin
        d  = i_reg_rdata;
        ok = 1'b1;
      end else begin
        @(negedge i_clk);
      end
    end
  endtask : rd

  task automatic wr(input logic [4:0] a, input pic_pkg::pic_word_t d);
    @(negedge i_clk);
    o_reg_addr  = a;
    o_reg_wdata = d;
    o_reg_wr    = 1'b1;
    @(negedge i_clk);
    o_reg_wr    = 1'b0;
    o_reg_addr  = ~a;
    o_reg_wdata = ~d;
  endtask : wr
endmodule : pic_mgmt_model

// [bench/pic_phy_int_counters_tb_top.sv]
`include "pic_params.svh"

module pic_phy_int_counters_tb_top;
  timeunit 1ns;
  timeprecision 1ps;

  logic               i_clk;
  logic               i_rst_n;
  logic [4:0]         addr;
  logic               rd;
  logic               wr;
  logic [15:0]        wdata;
  logic [15:0]        rdata;
  logic               rvalid;
  logic               link;
  logic               irq;
  logic [4:0]         ev;
  int                 error_cnt;
  int                 checks_done;

  pic_phy_int_counters i_dut (
    .i_clk              (i_clk),
    .i_rst_n            (i_rst_n),
    .i_reg_addr         (addr),
    .i_reg_rd           (rd),
    .i_reg_wr           (wr),
    .i_reg_wdata        (wdata),
    .o_reg_rdata        (rdata),
    .o_reg_rvalid       (rvalid),
    .i_link_up          (link),
    .i_false_carrier    (ev[4]),
    .i_rx_frame_start   (ev[3]),
    .i_rx_symbol_err    (ev[2]),
    .i_rx_premature_end (ev[1]),
    .i_rx_frame_end     (ev[0]),
    .o_irq              (irq)
  );

  pic_mgmt_model i_mgmt (
    .i_clk        (i_clk),
    .i_reg_rdata  (rdata),
    .i_reg_rvalid (rvalid),
    .o_reg_addr   (addr),
    .o_reg_rd     (rd),
    .o_reg_wr     (wr),
    .o_reg_wdata  (wdata)
  );

  initial begin
    i_clk = 1'b0;
    forever #20 i_clk = ~i_clk;
  end

  task automatic close_out();
    $display("checks %0d mismatches %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : close_out

  task automatic chk(input logic [15:0] got, input logic [15:0] exp,
                     input string what);
    checks_done++;
    if (got !== exp) begin
      error_cnt++;
      $display("mismatch at %0t: %s got %h expected %h", $time, what, got,
               exp);
    end
  endtask : chk

  task automatic rc(input logic [4:0] a, input logic [15:0] exp);
    pic_pkg::pic_word_t d;
    bit                 ok;
    i_mgmt.rd(a, d, ok);
    chk({15'h0000, ok}, 16'h0001, "read answered");
    chk(d, exp, "read data");
  endtask : rc

  // read of 0x12 in the very cycle the link flips: the set must win
  task automatic rc_flip(input logic [15:0] exp);
    pic_pkg::pic_word_t d;
    bit                 ok;
    fork
      i_mgmt.rd(`PIC_ADDR_INT, d, ok);
      begin
        @(negedge i_clk);
        link = ~link;
      end
    join
    chk({15'h0000, ok}, 16'h0001, "read answered");
    chk(d, exp, "read data");
  endtask : rc_flip

  // waits one cycle, then holds the event vector for n cycles and drops it to idle
  task automatic ev_run(input logic [4:0] v, input int n);
    @(negedge i_clk);
    ev = v;
    repeat (n) @(negedge i_clk);
    ev = 5'h00;
  endtask : ev_run

  task automatic flip_link();
    @(negedge i_clk);
    link = ~link;
    repeat (2) @(negedge i_clk);
  endtask : flip_link

  initial begin
    repeat (90000) @(posedge i_clk);
    error_cnt++;
    $display("mismatch at %0t: watchdog expired", $time);
    close_out();
  end

  initial begin
    i_rst_n = 1'b0;
    link    = 1'b0;
    ev      = 5'h00;
    repeat (3) @(posedge i_clk);
    @(negedge i_clk);
    i_rst_n = 1'b1;
    repeat (2) @(negedge i_clk);
    chk({15'h0000, irq}, 16'h0000, "irq after reset");
    rc(`PIC_ADDR_INT, 16'h0000);
    $display("test reset done");

    flip_link();
    chk({15'h0000, irq}, 16'h0000, "irq while disabled");
    rc(`PIC_ADDR_INT, 16'h0001);
    rc(`PIC_ADDR_INT, 16'h0000);
    i_mgmt.wr(`PIC_ADDR_INT, 16'hffff);
    rc(`PIC_ADDR_INT, 16'h0002);
    flip_link();
    chk({15'h0000, irq}, 16'h0001, "irq raised");
    rc(`PIC_ADDR_INT, 16'h0003);
    chk({15'h0000, irq}, 16'h0000, "irq dropped");
    flip_link();
    i_mgmt.wr(`PIC_ADDR_INT, 16'h0000);
    chk({15'h0000, irq}, 16'h0000, "irq gated off");
    rc(`PIC_ADDR_INT, 16'h0001);
    rc_flip(16'h0000);
    rc(`PIC_ADDR_INT, 16'h0001);
    $display("test link status done");

    ev_run(5'h10, 3);
    i_mgmt.wr(`PIC_ADDR_FCC, 16'h1234);
    rc(`PIC_ADDR_FCC, 16'h0003);
    rc(`PIC_ADDR_DISC, 16'h0001);
    rc(`PIC_ADDR_FCC, 16'h0000);
    ev_run(5'h08, 1);
    ev_run(5'h10, 2);
    ev_run(5'h08, 1);
    ev_run(5'h10, 1);
    rc(`PIC_ADDR_DISC, 16'h0001);
    $display("test false carrier done");

    ev_run(5'h08, 1);
    ev_run(5'h04, 3);
    ev_run(5'h02, 1);
    ev_run(5'h05, 1);
    ev_run(5'h08, 1);
    ev_run(5'h01, 1);
    rc(`PIC_ADDR_ERRFRM, 16'h0001);
    rc(`PIC_ADDR_SYMERR, 16'h0004);
    rc(`PIC_ADDR_ERRFRM, 16'h0000);
    rc(5'h1f, 16'h0000);
    $display("test frame errors done");

    // long run: one count per cycle so the all-ones ceiling is reached fast
    ev_run(5'h04, 65537);
    rc(`PIC_ADDR_SYMERR, `PIC_CNT_MAX);
    rc(`PIC_ADDR_SYMERR, 16'h0000);
    $display("test saturation done");
    close_out();
  end
endmodule : pic_phy_int_counters_tb_top

// [src/pic_params.svh]
`ifndef PIC_PARAMS_SVH
`define PIC_PARAMS_SVH

// management register offsets
`define PIC_ADDR_INT      5'h12
`define PIC_ADDR_FCC      5'h13
`define PIC_ADDR_DISC     5'h14
`define PIC_ADDR_ERRFRM   5'h15
`define PIC_ADDR_SYMERR   5'h16

// interrupt register fields
`define PIC_INT_STS_BIT   0
`define PIC_INT_EN_BIT    1

// reset values
`define PIC_INT_EN_RST    1'b0
`define PIC_INT_STS_RST   1'b0
`define PIC_CNT_RST       16'h0000
`define PIC_RDATA_RST     16'h0000

// counter geometry
`define PIC_CNT_W         16
`define PIC_CNT_MAX       16'hffff
`define PIC_CNT_NUM       4

`endif

// [src/pic_phy_int_counters.sv]
// Functional notes
// - interrupt enable gates the interrupt line; reset value zero
// - link-change bit is visible and updates regardless of enable
// - a link integrity change in either direction sets link-change bit
// - a read of 0x12 clears link-change bit; a later change sets it
// - false-carrier counter: 16 bits, one count per bad start delimiter
// - all counters stop at all-ones, never wrap
// - counters return value on read and then clear; an event in the read cycle restarts them at one
// - disconnect counter: 16 bits, one count per disconnect event
// - two or more back-to-back false carriers make one disconnect event
// - error frame counter advances at most once per errored frame
// - symbol error counter advances once per individual symbol error
`include "pic_params.svh"

module pic_phy_int_counters (
  input  wire logic                  i_clk,
  input  wire logic                  i_rst_n,
  input  wire logic [4:0]            i_reg_addr,
  input  wire logic                  i_reg_rd,
  input  wire logic                  i_reg_wr,
  input  wire logic [15:0]           i_reg_wdata,
  output logic [15:0]                o_reg_rdata,
  output logic                       o_reg_rvalid,
  input  wire logic                  i_link_up,
  input  wire logic                  i_false_carrier,
  input  wire logic                  i_rx_frame_start,
  input  wire logic                  i_rx_symbol_err,
  input  wire logic                  i_rx_premature_end,
  input  wire logic                  i_rx_frame_end,
  output logic                       o_irq
);

  logic                       int_en_ff;
  logic                       nxt_int_en;
  logic                       int_sts_ff;
  logic                       nxt_int_sts;
  logic                       irq_ff;
  logic                       nxt_irq;
  logic                       link_prev_ff;
  logic                       nxt_link_prev;
  logic                       primed_ff;
  logic                       nxt_primed;
  logic                       link_change;
  logic                       rd_int;
  logic                       wr_int;

  pic_pkg::pic_fc_run_t       fc_run_ff;
  pic_pkg::pic_fc_run_t       nxt_fc_run;
  logic                       disc_evt;

  logic                       frm_err_ff;
  logic                       nxt_frm_err;
  logic                       frm_err_evt;

  pic_pkg::pic_word_t         rdata_ff;
  pic_pkg::pic_word_t         nxt_rdata;
  logic                       rvalid_ff;
  logic                       nxt_rvalid;

  logic [`PIC_CNT_NUM-1:0]    cnt_inc;
  logic [`PIC_CNT_NUM-1:0]    cnt_clr;
  logic [`PIC_CNT_W-1:0]      cnt_val [`PIC_CNT_NUM];

  assign rd_int = i_reg_rd && i_reg_addr == `PIC_ADDR_INT;
  assign wr_int = i_reg_wr && i_reg_addr == `PIC_ADDR_INT;
  // the first cycle after reset only learns the link level, so a link
  // that is already up at reset does not raise a spurious change
  assign link_change = primed_ff && (i_link_up != link_prev_ff);

  // interrupt register and link monitor
  always_comb begin
    nxt_link_prev = i_link_up;
    nxt_primed    = 1'b1;
    nxt_int_en    = int_en_ff;
    nxt_int_sts   = int_sts_ff;
    if (wr_int) begin
      nxt_int_en = i_reg_wdata[`PIC_INT_EN_BIT];
    end
    if (rd_int) begin
      nxt_int_sts = 1'b0;
    end
    // set wins over the read clear, independent of the enable
    if (link_change) begin
      nxt_int_sts = 1'b1;
    end
    nxt_irq = nxt_int_en && nxt_int_sts;
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      int_en_ff    <= `PIC_INT_EN_RST;
      int_sts_ff   <= `PIC_INT_STS_RST;
      irq_ff       <= 1'b0;
      link_prev_ff <= 1'b0;
      primed_ff    <= 1'b0;
    end else begin
      int_en_ff    <= nxt_int_en;
      int_sts_ff   <= nxt_int_sts;
      irq_ff       <= nxt_irq;
      link_prev_ff <= nxt_link_prev;
      primed_ff    <= nxt_primed;
    end
  end

  assign o_irq = irq_ff;

  // false-carrier run tracking: a good start delimiter ends the run;
  // a run of two or more counts a single disconnect
  always_comb begin
    nxt_fc_run = fc_run_ff;
    disc_evt   = 1'b0;
    if (i_rx_frame_start) begin
      nxt_fc_run = pic_pkg::PIC_FC_IDLE;
    end else if (i_false_carrier) begin
      case (fc_run_ff)
        pic_pkg::PIC_FC_IDLE: begin
          nxt_fc_run = pic_pkg::PIC_FC_ONE;
        end
        pic_pkg::PIC_FC_ONE: begin
          nxt_fc_run = pic_pkg::PIC_FC_DONE;
          disc_evt   = 1'b1;
        end
        pic_pkg::PIC_FC_DONE: begin
          nxt_fc_run = pic_pkg::PIC_FC_DONE;
        end
        default: begin
          nxt_fc_run = pic_pkg::PIC_FC_IDLE;
        end
      endcase
    end
  end

  // frame error tracking: remembers any error inside the current frame
  always_comb begin
    frm_err_evt = i_rx_frame_end &&
                  (frm_err_ff || i_rx_symbol_err || i_rx_premature_end);
    nxt_frm_err = frm_err_ff;
    if (i_rx_frame_start || i_rx_frame_end) begin
      nxt_frm_err = 1'b0;
    end else if (i_rx_symbol_err || i_rx_premature_end) begin
      nxt_frm_err = 1'b1;
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      fc_run_ff  <= pic_pkg::PIC_FC_IDLE;
      frm_err_ff <= 1'b0;
    end else begin
      fc_run_ff  <= nxt_fc_run;
      frm_err_ff <= nxt_frm_err;
    end
  end

  assign cnt_inc[0] = i_false_carrier;
  assign cnt_inc[1] = disc_evt;
  assign cnt_inc[2] = frm_err_evt;
  assign cnt_inc[3] = i_rx_symbol_err;

  // counters ignore writes: only reads and events reach them
  genvar gi;
  generate
    for (gi = 0; gi < `PIC_CNT_NUM; gi = gi + 1) begin : g_cnt
      assign cnt_clr[gi] = i_reg_rd &&
                           i_reg_addr == 5'(`PIC_ADDR_FCC + gi);
      pic_sat_counter u_cnt (
        .i_clk   (i_clk),
        .i_rst_n (i_rst_n),
        .i_inc   (cnt_inc[gi]),
        .i_clr   (cnt_clr[gi]),
        .o_count (cnt_val[gi])
      );
    end
  endgenerate

  // read data is captured in the read cycle, before the clear lands
  always_comb begin
    nxt_rdata  = rdata_ff;
    nxt_rvalid = i_reg_rd;
    if (i_reg_rd) begin
      case (i_reg_addr)
        `PIC_ADDR_INT: nxt_rdata = {14'h0000, int_en_ff, int_sts_ff};
        `PIC_ADDR_FCC:    nxt_rdata = cnt_val[0];
        `PIC_ADDR_DISC:   nxt_rdata = cnt_val[1];
        `PIC_ADDR_ERRFRM: nxt_rdata = cnt_val[2];
        `PIC_ADDR_SYMERR: nxt_rdata = cnt_val[3];
        default:          nxt_rdata = 16'h0000;
      endcase
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rdata_ff  <= `PIC_RDATA_RST;
      rvalid_ff <= 1'b0;
    end else begin
      rdata_ff  <= nxt_rdata;
      rvalid_ff <= nxt_rvalid;
    end
  end

  assign o_reg_rdata  = rdata_ff;
  assign o_reg_rvalid = rvalid_ff;

  property p_irq_gate;
    @(posedge i_clk) disable iff (!i_rst_n)
    !int_en_ff |-> !o_irq;
  endproperty
  a_irq_gate: assert property (p_irq_gate)
    else $error("interrupt asserted while disabled");

  property p_sts_unmasked;
    @(posedge i_clk) disable iff (!i_rst_n)
    link_change && !int_en_ff && !wr_int |=> int_sts_ff && !o_irq;
  endproperty
  a_sts_unmasked: assert property (p_sts_unmasked)
    else $error("status not set while interrupt disabled");

  property p_link_set;
    @(posedge i_clk) disable iff (!i_rst_n)
    primed_ff && $changed(i_link_up) |=> int_sts_ff;
  endproperty
  a_link_set: assert property (p_link_set)
    else $error("link change not flagged");

  property p_rd_clr;
    @(posedge i_clk) disable iff (!i_rst_n)
    rd_int && int_sts_ff && !link_change
      |=> !int_sts_ff && o_reg_rdata[`PIC_INT_STS_BIT];
  endproperty
  a_rd_clr: assert property (p_rd_clr)
    else $error("status not self-cleared after read");

  property p_irq_follow;
    @(posedge i_clk) disable iff (!i_rst_n)
    o_irq == (int_en_ff && int_sts_ff);
  endproperty
  a_irq_follow: assert property (p_irq_follow)
    else $error("interrupt line disagrees with enable and status");

  property p_disc_two;
    @(posedge i_clk) disable iff (!i_rst_n)
    i_false_carrier && !i_rx_frame_start ##1
      i_false_carrier && !i_rx_frame_start && fc_run_ff == pic_pkg::PIC_FC_ONE
      |-> disc_evt;
  endproperty
  a_disc_two: assert property (p_disc_two)
    else $error("back-to-back false carriers not a disconnect");

  property p_frm_once;
    @(posedge i_clk) disable iff (!i_rst_n)
    frm_err_evt |-> i_rx_frame_end ##1 !frm_err_ff;
  endproperty
  a_frm_once: assert property (p_frm_once)
    else $error("error frame counted outside frame end");

  property p_ro_write;
    @(posedge i_clk) disable iff (!i_rst_n)
    i_reg_wr && !i_reg_rd && i_reg_addr == `PIC_ADDR_FCC && !i_false_carrier
      |=> $stable(cnt_val[0]);
  endproperty
  a_ro_write: assert property (p_ro_write)
    else $error("write altered a counter");

  property p_rsvd_zero;
    @(posedge i_clk) disable iff (!i_rst_n)
    rd_int |=> o_reg_rdata[15:2] == 14'h0000;
  endproperty
  a_rsvd_zero: assert property (p_rsvd_zero)
    else $error("reserved interrupt bits not zero");

endmodule : pic_phy_int_counters

// [src/pic_pkg.sv]
package pic_pkg;

  typedef enum logic [1:0] {
    PIC_FC_IDLE = 2'b00,
    PIC_FC_ONE  = 2'b01,
    PIC_FC_DONE = 2'b10
  } pic_fc_run_t;

  typedef logic [15:0] pic_word_t;

endpackage : pic_pkg

// [src/pic_sat_counter.sv]
`include "pic_params.svh"

module pic_sat_counter (
  input  wire logic                  i_clk,
  input  wire logic                  i_rst_n,
  input  wire logic                  i_inc,
  input  wire logic                  i_clr,
  output logic [`PIC_CNT_W-1:0]      o_count
);

  logic [`PIC_CNT_W-1:0] cnt_ff;
  logic [`PIC_CNT_W-1:0] nxt_cnt;

  always_comb begin
    nxt_cnt = cnt_ff;
    if (i_clr) begin
      // an event in the read cycle is kept as the first new count
      nxt_cnt = i_inc ? `PIC_CNT_W'(1) : `PIC_CNT_RST;
    end else if (i_inc && cnt_ff != `PIC_CNT_MAX) begin
      nxt_cnt = cnt_ff + `PIC_CNT_W'(1);
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      cnt_ff <= `PIC_CNT_RST;
    end else begin
      cnt_ff <= nxt_cnt;
    end
  end

  assign o_count = cnt_ff;

  property p_cnt_inc;
    @(posedge i_clk) disable iff (!i_rst_n)
    i_inc && !i_clr && cnt_ff != `PIC_CNT_MAX
      |=> cnt_ff == $past(cnt_ff) + `PIC_CNT_W'(1);
  endproperty
  a_cnt_inc: assert property (p_cnt_inc)
    else $error("counter did not advance on event");

  property p_cnt_sat;
    @(posedge i_clk) disable iff (!i_rst_n)
    cnt_ff == `PIC_CNT_MAX && !i_clr |=> cnt_ff == `PIC_CNT_MAX;
  endproperty
  a_cnt_sat: assert property (p_cnt_sat)
    else $error("full counter wrapped");

  property p_cnt_clr;
    @(posedge i_clk) disable iff (!i_rst_n)
    i_clr && !i_inc |=> cnt_ff == `PIC_CNT_RST;
  endproperty
  a_cnt_clr: assert property (p_cnt_clr)
    else $error("counter not cleared after read");

endmodule : pic_sat_counter
